// ### test_two_wire_config_target.sv
// Purpose: Self-checking bench for twc_target.
// Assumes: 25 MHz clock, short reset count.
// Notes: Register model is an int array.
`timescale 1ns/1ps
module test_two_wire_config_target;
    localparam int RST_N = 300;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_reset_n = 1'b1;
    logic addr_sel = 1'b0;
    logic [7:0] stat1 = 8'h00;
    logic [7:0] stat2 = 8'h00;
    logic [7:0] cfg_addr = 8'h00;
    logic scl;
    logic sda_low;
    wire sda_pin;
    wire oe_n;
    wire [7:0] cfg_data;
    wire standby;
    wire busy;
    wire sda_wire = !sda_low && (oe_n || sda_pin);
    int mem [256];
    logic [7:0] wq [$];
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    twc_target #(.RST_CYCLES(RST_N), .DLY(3)) uut (
        .ref_clk_in(clk), .srst_in(srst), .ext_reset_n_in(ext_reset_n),
        .addr_sel_in(addr_sel), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_pin),
        .sda_oe_n_out(oe_n), .stat1_in(stat1), .stat2_in(stat2), .cfg_addr_in(cfg_addr),
        .cfg_data_out(cfg_data), .standby_out(standby), .reset_busy_out(busy)
    );
    twc_host_model host (.scl_out(scl), .sda_low_out(sda_low), .sda_line_in(sda_wire));
    initial begin
        forever #20 clk = !clk;
    end
    task automatic close_out();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t bit %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        for (int k = 0; k < RST_N + 50 && busy !== 1'b0; k++) @(negedge clk);
        check_bit(busy, 1'b0);
    endtask
    task automatic wr_regs(input logic [7:0] p);
        logic a;
        int i;
        i = p;
        host.start_cond();
        host.wr_byte({6'h26, addr_sel, 1'b0}, a);
        check_bit(a, 1'b1);
        host.wr_byte(p, a);
        check_bit(a, 1'b1);
        while (wq.size() > 0) begin
            mem[i % 256] = wq[0];
            host.wr_byte(wq.pop_front(), a);
            check_bit(a, 1'b1);
            i++;
        end
        host.stop_cond();
    endtask
    task automatic rd_regs(input logic [7:0] p, input int n);
        logic a;
        logic [7:0] d;
        int r;
        host.start_cond();
        host.wr_byte({6'h26, addr_sel, 1'b0}, a);
        host.wr_byte(p, a);
        host.start_cond();
        host.wr_byte({6'h26, addr_sel, 1'b1}, a);
        check_bit(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            r = (p + i) % 256;
            host.rd_byte(i < n - 1, d);
            check_byte(d, r == 1 ? stat1 : r == 2 ? stat2 : 8'(mem[r]));
        end
        host.stop_cond();
    endtask
    initial begin
        logic a;
        logic b;
        logic [7:0] v;
        logic [7:0] p;
        void'($urandom(32'h16EB));
        repeat (4) @(negedge clk);
        srst = 1'b0;
        check_bit(busy, 1'b1);
        wait_idle();
        for (int s = 0; s < 2; s++) begin
            @(negedge clk);
            addr_sel = s[0];
            repeat (4) @(negedge clk);
            for (int k = 0; k < 3; k++) begin
                v = k == 0 ? 8'h98 : k == 1 ? 8'h9A : 8'($urandom) & 8'hFE;
                host.start_cond();
                host.wr_byte(v, a);
                host.wr_byte(8'h00, b);
                host.stop_cond();
                check_bit(a, v[7:1] == {6'h26, addr_sel});
                check_bit(b, v[7:1] == {6'h26, addr_sel});
            end
        end
        p = 8'h10 + 8'($urandom_range(0, 223));
        repeat (4) wq.push_back(8'($urandom));
        host.glitch_en = 1'b1;
        wr_regs(p);
        host.glitch_en = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            cfg_addr = p + i[7:0];
            @(negedge clk);
            check_byte(cfg_data, 8'(mem[p + i]));
        end
        rd_regs(p, 4);
        @(negedge clk);
        stat1 = 8'($urandom);
        stat2 = 8'($urandom);
        rd_regs(8'h00, 4);
        wq.push_back(8'h0F);
        wr_regs(8'h2C);
        check_bit(standby, 1'b1);
        wq.push_back(8'($urandom));
        wr_regs(p);
        rd_regs(p, 2);
        @(negedge clk);
        ext_reset_n = 1'b0;
        repeat (2) @(negedge clk);
        ext_reset_n = 1'b1;
        foreach (mem[i]) mem[i] = 0;
        repeat (4) @(negedge clk);
        wait_idle();
        check_bit(standby, 1'b0);
        rd_regs(p, 2);
        close_out();
    end
endmodule // test_two_wire_config_target

// ### twc_defines.vh
// Purpose: Shared constants for the two-wire configuration target.
// Assumes: One 25 MHz reference clock; all times are counted in its cycles.
// Notes: Definitions only, no logic.
// What this block does
// RQ1 - Address is 100110 plus select pin
// RQ2 - Write address byte 0x98 or 0x9A
// RQ3 - Ignore bus activity until a start
// RQ4 - Start/stop are SDA edges with SCL high
// RQ5 - Seven address bits then direction bit
// RQ6 - Acknowledge matching address on ninth clock
// RQ7 - Repeated start begins new addressed transfer
// RQ8 - First written byte loads register pointer
// RQ9 - Pointer increments after every data byte
// RQ10 - Host reads via write, restart, read
// RQ11 - Sample written bits on delayed SCL rise
// RQ12 - Deglitch and delay SCL three clocks
// RQ13 - Change read data after delayed SCL fall
// RQ14 - SDA driven open drain only
// RQ15 - Host keeps SDA stable while SCL high
// RQ16 - Writing 0x0F to 0x2C enters standby
// RQ17 - Serial interface stays alive in standby
// RQ18 - Reset restores defaults over 512k cycles
// RQ19 - External reset pin equals power-up reset
// RQ20 - Mismatched address leaves SDA released
// RQ21 - Ack written bytes, stop read on NACK
`ifndef TWC_DEFINES_VH
`define TWC_DEFINES_VH

`define TWC_ADDR_HI 6'h26
`define TWC_RW_READ 1'b1
`define TWC_BYTE_BITS 4'h8
`define TWC_DEGLITCH_CYC 3
`define TWC_RST_CYCLES 524288
`define TWC_REG_STAT1 8'h01
`define TWC_REG_STAT2 8'h02
`define TWC_REG_STANDBY 8'h2C
`define TWC_STANDBY_CODE 8'h0F
`define TWC_REG_DEFAULT 8'h00

`endif

// ### twc_host_model.sv
// Purpose: Behavioural bus controller.
// Assumes: 320 ns bit period, SDA pulled up in the bench.
// Notes: SCL idles high; low phase stretched after a target-driven bit.
`timescale 1ns/1ps
module twc_host_model (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_line_in
);
    logic glitch_en = 1'b0;
    logic last_dev = 1'b0;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Target answers late in the low phase, so give it room to let go
    task automatic bit_xfer(input logic b, input logic dev, output logic r);
        if (glitch_en) begin
            #5 scl_out = 1'b1;
            #25 scl_out = 1'b0;
            #50;
        end else #40;
        sda_low_out = !b;
        // Stretch when the target drives this bit or let go of the last one
        #((last_dev || dev) ? 280 : 120) scl_out = 1'b1;
        #150 r = sda_line_in;
        #10 scl_out = 1'b0;
        last_dev = dev;
    endtask
    task automatic start_cond();
        sda_low_out = 1'b0;
        #(last_dev ? 320 : 80) scl_out = 1'b1;
        #80 sda_low_out = 1'b1;
        #160 scl_out = 1'b0;
        last_dev = 1'b0;
    endtask
    task automatic stop_cond();
        #40 sda_low_out = 1'b1;
        #(last_dev ? 280 : 120) scl_out = 1'b1;
        #80 sda_low_out = 1'b0;
        #160 last_dev = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], 1'b0, r);
        bit_xfer(1'b1, 1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, 1'b1, r);
            d[i] = r;
        end
        bit_xfer(!ack, 1'b0, r);
    endtask
endmodule // twc_host_model

// ### twc_line_filter.v
// Purpose: Synchronise one bus line and accept a new level only once stable.
// Assumes: Line is asynchronous to ref_clk_in.
// Notes: Output lags the pin by the sync stages plus the stability count.
`timescale 1ns/1ps
`include "twc_defines.vh"
module twc_line_filter #(
    parameter DLY = `TWC_DEGLITCH_CYC
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire line_in,
    output reg level_out,
    output reg rise_out,
    output reg fall_out
);
    reg sync1;
    reg sync2;
    reg [3:0] stable_cnt;

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            stable_cnt <= 4'h0;
            level_out <= 1'b1;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            sync1 <= line_in;
            sync2 <= sync1;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            // Pulses shorter than DLY cycles never reach level_out
            if (sync2 != level_out) begin // RQ12
                if (stable_cnt == DLY[3:0] - 4'h1) begin
                    level_out <= sync2;
                    rise_out <= sync2;
                    fall_out <= ~sync2;
                    stable_cnt <= 4'h0;
                end else begin
                    stable_cnt <= stable_cnt + 4'h1;
                end
            end else begin
                stable_cnt <= 4'h0;
            end
        end
    end
endmodule // twc_line_filter

// ### twc_reset_seq.v
// Purpose: Long reset sequence started by power-up or the external reset pin.
// Assumes: restart_in comes from logic on ref_clk_in.
// Notes: RST_CYCLES must be at least 256 so every register gets cleared.
`timescale 1ns/1ps
`include "twc_defines.vh"
module twc_reset_seq #(
    parameter RST_CYCLES = `TWC_RST_CYCLES
) (
    input wire ref_clk_in,
    input wire restart_in,
    output reg busy_out,
    output wire [7:0] index_out
);
    reg [19:0] cnt;

    assign index_out = cnt[7:0];

    always @(posedge ref_clk_in) begin
        if (restart_in) begin // RQ18 RQ19
            cnt <= 20'h00000;
            busy_out <= 1'b1;
        end else if (busy_out) begin
            cnt <= cnt + 20'h00001;
            if (cnt == RST_CYCLES[19:0] - 20'h00001) begin // RQ18
                busy_out <= 1'b0;
            end
        end
    end
endmodule // twc_reset_seq

// ### twc_target.v
// Purpose: Two-wire bus target giving a host access to configuration registers.
// Assumes: SCL driven by the host; SDA open drain; pins asynchronous.
// Notes: Status registers are read-only and track the status inputs live.
`timescale 1ns/1ps
`include "twc_defines.vh"
module twc_target #(
    parameter RST_CYCLES = `TWC_RST_CYCLES,
    parameter DLY = `TWC_DEGLITCH_CYC
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire ext_reset_n_in,
    input wire addr_sel_in,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_n_out,
    input wire [7:0] stat1_in,
    input wire [7:0] stat2_in,
    input wire [7:0] cfg_addr_in,
    output reg [7:0] cfg_data_out,
    output reg standby_out,
    output wire reset_busy_out
);
    localparam ST_IDLE = 7'h01;
    localparam ST_ADDR = 7'h02;
    localparam ST_AACK = 7'h04;
    localparam ST_WR = 7'h08;
    localparam ST_WACK = 7'h10;
    localparam ST_RD = 7'h20;
    localparam ST_RACK = 7'h40;

    reg [7:0] regs [0:255];
    reg rstn_s1;
    reg rstn_s2;
    reg sel_s1;
    reg sel_s2;
    reg [6:0] state;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg [3:0] bit_cnt;
    reg [7:0] ptr;
    reg first_byte;
    reg host_ack;
    wire scl_lvl;
    wire scl_rise;
    wire scl_fall;
    wire sda_lvl;
    wire sda_rise;
    wire sda_fall;
    wire [7:0] rst_idx;
    wire busy;
    wire start_det;
    wire stop_det;
    wire byte_done;
    wire [7:0] rd_now;

    // Value seen by the host when reading register a
    function [7:0] rd_value;
        input [7:0] a;
        input [7:0] mem_val;
        input [7:0] s1;
        input [7:0] s2;
        begin
            if (a == `TWC_REG_STAT1) begin
                rd_value = s1; // RQ17
            end else if (a == `TWC_REG_STAT2) begin
                rd_value = s2;
            end else begin
                rd_value = mem_val;
            end
        end
    endfunction

    // Pin synchronisers for the reset and address-select pins
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            rstn_s1 <= 1'b1;
            rstn_s2 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            rstn_s1 <= ext_reset_n_in;
            rstn_s2 <= rstn_s1;
            sel_s1 <= addr_sel_in;
            sel_s2 <= sel_s1;
        end
    end

    twc_reset_seq #(
        .RST_CYCLES(RST_CYCLES)
    ) u_rst (
        .ref_clk_in(ref_clk_in),
        .restart_in(srst_in | ~rstn_s2), // RQ19
        .busy_out(busy),
        .index_out(rst_idx)
    );

    // SDA goes through the same delay so start/stop stay aligned to SCL
    twc_line_filter #(
        .DLY(DLY)
    ) u_scl (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .line_in(scl_in),
        .level_out(scl_lvl),
        .rise_out(scl_rise),
        .fall_out(scl_fall)
    );

    twc_line_filter #(
        .DLY(DLY)
    ) u_sda (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .line_in(sda_in),
        .level_out(sda_lvl),
        .rise_out(sda_rise),
        .fall_out(sda_fall)
    );

    assign reset_busy_out = busy;
    assign start_det = sda_fall & scl_lvl; // RQ4
    assign stop_det = sda_rise & scl_lvl; // RQ4
    assign byte_done = scl_fall & (bit_cnt == `TWC_BYTE_BITS);
    assign rd_now = rd_value(ptr, regs[ptr], stat1_in, stat2_in);
    // Output data is always low; only the enable moves
    assign sda_out = 1'b0; // RQ14

    // Register array: cleared during reset, written by the bus
    always @(posedge ref_clk_in) begin
        if (busy) begin
            regs[rst_idx] <= `TWC_REG_DEFAULT; // RQ18
        end else if (state == ST_WR && byte_done && !first_byte) begin
            regs[ptr] <= shreg;
        end
    end

    always @(posedge ref_clk_in) begin
        if (busy) begin
            cfg_data_out <= `TWC_REG_DEFAULT;
        end else begin
            cfg_data_out <= regs[cfg_addr_in];
        end
    end

    always @(posedge ref_clk_in) begin
        if (busy) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            txreg <= 8'h00;
            bit_cnt <= 4'h0;
            ptr <= 8'h00;
            first_byte <= 1'b0;
            host_ack <= 1'b0;
            sda_oe_n_out <= 1'b1;
            standby_out <= 1'b0;
        end else if (start_det) begin
            // Any start, repeated or not, restarts address reception
            state <= ST_ADDR; // RQ3 RQ7
            bit_cnt <= 4'h0;
            sda_oe_n_out <= 1'b1;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe_n_out <= 1'b1;
        end else begin
            // Standby leaves this interface running on the reference clock
            case (state)
                ST_IDLE: begin
                    sda_oe_n_out <= 1'b1; // RQ3
                end
                ST_ADDR: begin
                    if (scl_rise) begin // RQ11 RQ5
                        shreg <= {shreg[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        if (shreg[7:1] == {`TWC_ADDR_HI, sel_s2}) begin // RQ1 RQ2
                            sda_oe_n_out <= 1'b0; // RQ6
                            state <= ST_AACK;
                        end else begin
                            state <= ST_IDLE; // RQ20
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin // RQ13
                        if (shreg[0] == `TWC_RW_READ) begin // RQ5 RQ10
                            txreg <= rd_now;
                            sda_oe_n_out <= rd_now[7];
                            state <= ST_RD;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            first_byte <= 1'b1;
                            state <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin // RQ11
                        shreg <= {shreg[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        sda_oe_n_out <= 1'b0; // RQ21
                        first_byte <= 1'b0;
                        if (first_byte) begin
                            ptr <= shreg; // RQ8
                        end else begin
                            ptr <= ptr + 8'h01; // RQ9
                            if (ptr == `TWC_REG_STANDBY) begin
                                standby_out <= (shreg == `TWC_STANDBY_CODE); // RQ16
                            end
                        end
                        state <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_n_out <= 1'b1;
                        state <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        sda_oe_n_out <= 1'b1;
                        ptr <= ptr + 8'h01; // RQ9
                        state <= ST_RACK;
                    end else if (scl_fall) begin
                        txreg <= {txreg[6:0], 1'b0}; // RQ13
                        sda_oe_n_out <= txreg[6];
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        host_ack <= ~sda_lvl;
                    end else if (scl_fall) begin
                        if (host_ack) begin
                            txreg <= rd_now;
                            sda_oe_n_out <= rd_now[7];
                            state <= ST_RD;
                        end else begin
                            state <= ST_IDLE; // RQ21
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                end
            endcase
        end
    end
endmodule // twc_target

// ### twc_target_asserts.sv
// Purpose: Port checks for the two-wire target.
// Assumes: One clock, srst_in synchronous.
// Notes: Bound to twc_target below.
`timescale 1ns/1ps
module twc_target_chk #(
    parameter RST_CYCLES = 524288,
    parameter DLY = 3
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire ext_reset_n_in,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_n_out,
    input wire [7:0] cfg_data_out,
    input wire standby_out,
    input wire reset_busy_out
);
    int busy_cnt;
    // Pin restart lags by its synchroniser, hence the slack below
    always @(posedge ref_clk_in) begin
        if (srst_in || !ext_reset_n_in) busy_cnt <= 0;
        else if (reset_busy_out) busy_cnt <= busy_cnt + 1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_busy_release: assert property (reset_busy_out |-> sda_oe_n_out)
        else $error("sda pulled while busy");
    // Outputs clear on the edge after busy shows, so allow that one cycle
    chk_busy_standby: assert property (reset_busy_out && $past(reset_busy_out) |-> !standby_out)
        else $error("standby while busy");
    chk_busy_clear: assert property (reset_busy_out && $past(reset_busy_out) |-> cfg_data_out == 8'h00)
        else $error("data not cleared");
    chk_reset_length: assert property ($fell(reset_busy_out) |-> busy_cnt >= RST_CYCLES - 1 && busy_cnt <= RST_CYCLES + 4)
        else $error("reset length wrong");
    chk_ext_restart: assert property ($fell(ext_reset_n_in) |-> ##[1:4] reset_busy_out)
        else $error("pin reset ignored");
    chk_drive_after_fall: assert property (!reset_busy_out && $changed(sda_oe_n_out) |-> !$past(scl_in, 4))
        else $error("sda moved with scl high");
    chk_standby_on_fall: assert property ($rose(standby_out) |-> !$past(scl_in, 4))
        else $error("standby off bit timing");
    cover property ($fell(sda_oe_n_out));
    cover property ($rose(standby_out));
    cover property ($fell(reset_busy_out));
endmodule // twc_target_chk
bind twc_target twc_target_chk #(.RST_CYCLES(RST_CYCLES), .DLY(DLY)) chk (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ext_reset_n_in(ext_reset_n_in),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .cfg_data_out(cfg_data_out), .standby_out(standby_out), .reset_busy_out(reset_busy_out)
);
